// [rtl/lin_status_pkg.sv]
// constants for the lin status flag block: register map, field
// positions, reset values and the idle timeout count
// assumes a 200 mhz system clock and a 32-bit classic wishbone bus
package lin_status_pkg;
	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [5:0] CTRL_IDX = 6'h08; // controller_control_reg
	localparam logic [5:0] STATUS_IDX = 6'h09; // bus_controller_status
	localparam logic [5:0] IRQ_STAT_IDX = 6'h0A; // sticky event bits
	localparam logic [5:0] IRQ_MASK_IDX = 6'h0B; // event enables
	// ==========================================================
	// status field positions
	localparam int ACT_BIT = 7; // bus activity
	localparam int IDLE_BIT = 6; // bus_idle_timeout
	localparam int ABORT_BIT = 5; // aborted transmission
	localparam int DREQ_BIT = 4; // data_request_flag
	localparam int INT_BIT = 3; // interrupt_pending_flag
	localparam int ERR_BIT = 2; // communication error
	localparam int WAKE_BIT = 1; // wakeup seen or sent
	localparam int DONE_BIT = 0; // transmission complete
	// ==========================================================
	// control field positions
	localparam int STOP_BIT = 7; // stop request, action only
	localparam int CLR_INT_BIT = 3; // clear_interrupt_bit, action only
	localparam int CLR_ERR_BIT = 2; // clear_error_bit, action only
	localparam int SLAVE_BIT = 0; // slave mode select, stored
	// ==========================================================
	// reset values
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] IRQ_RST = 8'h00;
	localparam logic SLAVE_RST = 1'b0;
	// ==========================================================
	// idle timeout
	localparam int unsigned CLK_HZ = 200_000_000; // system clock rate
	localparam int unsigned IDLE_TIME_S = 4; // idle time in seconds
	localparam longint unsigned IDLE_CYCLES = 64'(IDLE_TIME_S) * 64'(CLK_HZ);
endpackage

// [rtl/idle_tmr_if.sv]
// handshake between the flag logic and its idle timer
// assumes both ends sit on the same system clock
`timescale 1ns/10ps
`default_nettype none
interface idle_tmr_if;
	logic run; // timer may count
	logic restart; // bus activity seen, start over
	logic expired; // idle time has elapsed
	modport ctl (output run, output restart, input expired);
	modport tmr (input run, input restart, output expired);
endinterface
`default_nettype wire

// [rtl/idle_timer.sv]
// idle timer: counts quiet cycles while allowed, flags expiry
// assumes run and restart come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module idle_timer #(
	parameter int unsigned IDLE_CYCLES = 32'(lin_status_pkg::IDLE_CYCLES)
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// control side
	idle_tmr_if.tmr tif
);
	logic [31:0] count; // quiet cycles so far
	logic [31:0] next_count;
	logic expired; // latched expiry
	logic next_expired;

	// ==========================================================
	// next state: restart or stop clears, otherwise count up
	always_comb begin
		next_count = count;
		next_expired = expired;
		if (tif.restart || !tif.run) begin
			next_count = 32'h0000_0000;
			next_expired = 1'b0;
		end else if (count >= IDLE_CYCLES - 32'h0000_0001) begin
			next_expired = 1'b1; // hold at the limit
		end else begin
			next_count = count + 32'h0000_0001;
		end
	end

	// registers, frozen while the clock enable is low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count <= 32'h0000_0000;
			expired <= 1'b0;
		end else if (ce_i) begin
			count <= next_count;
			expired <= next_expired;
		end
	end

	assign tif.expired = expired;
endmodule
`default_nettype wire

// [rtl/lin_status_flags.sv]
// lin controller status flags with wishbone register access
// assumes protocol engine events arrive as single-cycle pulses
// on clk_i; levels bus_active_i, sleep_i, wake_tx_i likewise
//
// How it works
// RULE_01: activity flag follows detected bus activity
// RULE_02: slave idle four seconds, not asleep: flag
// RULE_03: slave abort on busy break or stop
// RULE_04: slave clean break clears the abort flag
// RULE_05: slave identifier received sets data request
// RULE_06: interrupt flag cleared only by clear bit
// RULE_07: error flag cleared only by clear bit
// RULE_08: wakeup flag while sending or after receiving
// RULE_09: done cleared at transmission start
// RULE_10: done set when transmission finishes
// RULE_11: all status flags zero after reset
// RULE_12: status register ignores writes
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module lin_status_flags #(
	parameter int unsigned IDLE_CYCLES = 32'(lin_status_pkg::IDLE_CYCLES)
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// protocol engine events
	input wire logic bus_active_i,
	input wire logic sleep_i,
	input wire logic synch_break_i,
	input wire logic tx_start_i,
	input wire logic tx_end_i,
	input wire logic id_rx_i,
	input wire logic int_req_i,
	input wire logic err_i,
	input wire logic wake_tx_i,
	input wire logic wake_rx_i,
	// outputs
	output logic [7:0] status_o,
	output logic stop_o,
	output logic irq_o
);
	// ==========================================================
	// state
	logic [7:0] flags; // bus_controller_status
	logic [7:0] next_flags;
	logic in_tx; // transmission under way
	logic next_in_tx;
	logic wake_rx_seen; // wakeup received, held
	logic next_wake_rx_seen;
	logic slave_mode; // stored control bit
	logic next_slave_mode;
	logic [7:0] irq_stat; // sticky event bits
	logic [7:0] next_irq_stat;
	logic [7:0] irq_mask; // event enables
	logic [7:0] next_irq_mask;
	logic ack; // bus answer
	logic next_ack;
	logic [31:0] rdata; // bus read data
	logic [31:0] next_rdata;
	logic stop_pulse; // stop strobe to the engine
	logic next_stop_pulse;
	logic irq; // interrupt line
	logic next_irq;

	// ==========================================================
	// bus decode
	logic req; // new access, not yet answered
	logic wr_lane0; // write hitting the low byte
	logic ctrl_wr; // write to control
	logic stop_cmd; // stop requested
	logic clr_int_cmd; // clear_interrupt_bit written
	logic clr_err_cmd; // clear_error_bit written
	logic [7:0] events; // flags that rise this cycle

	assign req = wb_cyc_i && wb_stb_i && !ack;
	assign wr_lane0 = req && wb_we_i && wb_sel_i[0];
	assign ctrl_wr = wr_lane0 && (wb_adr_i[7:2] == lin_status_pkg::CTRL_IDX);
	assign stop_cmd = ctrl_wr && wb_dat_i[lin_status_pkg::STOP_BIT];
	assign clr_int_cmd = ctrl_wr && wb_dat_i[lin_status_pkg::CLR_INT_BIT];
	assign clr_err_cmd = ctrl_wr && wb_dat_i[lin_status_pkg::CLR_ERR_BIT];

	// ==========================================================
	// idle timer
	idle_tmr_if tif ();

	// counts only in slave mode while awake and quiet
	assign tif.run = slave_mode && !sleep_i; // RULE_02
	assign tif.restart = bus_active_i;

	idle_timer #(.IDLE_CYCLES(IDLE_CYCLES)) u_idle (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.tif(tif)
	);

	// ==========================================================
	// flag next values; hardware sets win over software clears
	always_comb begin
		next_flags = flags;
		next_in_tx = in_tx;
		next_wake_rx_seen = wake_rx_seen;
		// activity mirrors the engine
		next_flags[lin_status_pkg::ACT_BIT] = bus_active_i; // RULE_01
		// idle timeout only in slave mode, before sleep
		next_flags[lin_status_pkg::IDLE_BIT] = tif.expired && slave_mode && !sleep_i; // RULE_02
		// abort: clean break clears, busy break or stop sets
		if (slave_mode && synch_break_i && !in_tx) begin
			next_flags[lin_status_pkg::ABORT_BIT] = 1'b0; // RULE_04
		end
		if (slave_mode && ((synch_break_i && in_tx) || stop_cmd)) begin
			next_flags[lin_status_pkg::ABORT_BIT] = 1'b1; // RULE_03
		end
		// data request: new frame clears, identifier sets
		if (synch_break_i) begin
			next_flags[lin_status_pkg::DREQ_BIT] = 1'b0;
		end
		if (slave_mode && id_rx_i) begin
			next_flags[lin_status_pkg::DREQ_BIT] = 1'b1; // RULE_05
		end
		// pending interrupt, software clear only
		if (clr_int_cmd) begin
			next_flags[lin_status_pkg::INT_BIT] = 1'b0; // RULE_06
		end
		if (int_req_i) begin
			next_flags[lin_status_pkg::INT_BIT] = 1'b1; // RULE_06
		end
		// error, software clear only
		if (clr_err_cmd) begin
			next_flags[lin_status_pkg::ERR_BIT] = 1'b0; // RULE_07
		end
		if (err_i) begin
			next_flags[lin_status_pkg::ERR_BIT] = 1'b1; // RULE_07
		end
		// received wakeup held until the next transmission
		if (tx_start_i) begin
			next_wake_rx_seen = 1'b0;
		end
		if (wake_rx_i) begin
			next_wake_rx_seen = 1'b1;
		end
		next_flags[lin_status_pkg::WAKE_BIT] = wake_tx_i || next_wake_rx_seen; // RULE_08
		// done: start clears, end sets
		if (tx_start_i) begin
			next_in_tx = 1'b1;
			next_flags[lin_status_pkg::DONE_BIT] = 1'b0; // RULE_09
		end
		if (tx_end_i) begin
			next_in_tx = 1'b0;
			next_flags[lin_status_pkg::DONE_BIT] = 1'b1; // RULE_10
		end
	end

	// flag registers; reset overrides the clock enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags <= lin_status_pkg::STATUS_RST; // RULE_11
			in_tx <= 1'b0;
			wake_rx_seen <= 1'b0;
		end else if (ce_i) begin
			flags <= next_flags;
			in_tx <= next_in_tx;
			wake_rx_seen <= next_wake_rx_seen;
		end
	end

	// ==========================================================
	// interrupt status: rising flags latch, write one to clear
	assign events = next_flags & ~flags;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_irq
			always_comb begin
				next_irq_stat[gi] = irq_stat[gi];
				// a write of one clears the bit
				if (wr_lane0 && (wb_adr_i[7:2] == lin_status_pkg::IRQ_STAT_IDX)
						&& wb_dat_i[gi]) begin
					next_irq_stat[gi] = 1'b0;
				end
				// a new event beats the clear
				if (events[gi]) begin
					next_irq_stat[gi] = 1'b1;
				end
			end
		end
	endgenerate

	// ==========================================================
	// bus registers, answer and outputs
	always_comb begin
		next_slave_mode = slave_mode;
		next_irq_mask = irq_mask;
		next_ack = wb_cyc_i && wb_stb_i && !ack;
		next_rdata = 32'h0000_0000;
		// stop strobe lasts one cycle
		next_stop_pulse = stop_cmd;
		if (ctrl_wr) begin
			next_slave_mode = wb_dat_i[lin_status_pkg::SLAVE_BIT];
		end
		if (wr_lane0 && (wb_adr_i[7:2] == lin_status_pkg::IRQ_MASK_IDX)) begin
			next_irq_mask = wb_dat_i[7:0];
		end
		// a write to the status index stores nothing
		if (req && !wb_we_i) begin
			unique case (wb_adr_i[7:2])
				lin_status_pkg::CTRL_IDX: begin
					next_rdata[lin_status_pkg::SLAVE_BIT] = slave_mode;
				end
				lin_status_pkg::STATUS_IDX: begin
					next_rdata[7:0] = flags; // RULE_12
				end
				lin_status_pkg::IRQ_STAT_IDX: begin
					next_rdata[7:0] = irq_stat;
				end
				lin_status_pkg::IRQ_MASK_IDX: begin
					next_rdata[7:0] = irq_mask;
				end
				default: begin
					next_rdata = 32'h0000_0000; // unmapped reads zero
				end
			endcase
		end
		next_irq = |(next_irq_stat & next_irq_mask);
	end

	// bus and interrupt registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slave_mode <= lin_status_pkg::SLAVE_RST;
			irq_stat <= lin_status_pkg::IRQ_RST;
			irq_mask <= lin_status_pkg::IRQ_RST;
			ack <= 1'b0;
			rdata <= 32'h0000_0000;
			stop_pulse <= 1'b0;
			irq <= 1'b0;
		end else if (ce_i) begin
			slave_mode <= next_slave_mode;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			ack <= next_ack;
			rdata <= next_rdata;
			stop_pulse <= next_stop_pulse;
			irq <= next_irq;
		end
	end

	assign wb_ack_o = ack;
	assign wb_dat_o = rdata;
	assign status_o = flags;
	assign stop_o = stop_pulse;
	assign irq_o = irq;

	// ==========================================================
	// checks
	logic hw_quiet; // no event that may move a flag
	assign hw_quiet = !synch_break_i && !tx_start_i && !tx_end_i && !id_rx_i
		&& !int_req_i && !err_i && !wake_rx_i && !tif.expired
		&& (bus_active_i == flags[lin_status_pkg::ACT_BIT])
		&& (wake_tx_i == flags[lin_status_pkg::WAKE_BIT]);

	a_active_follows: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
		ce_i |=> flags[lin_status_pkg::ACT_BIT] == $past(bus_active_i))
		else $error("activity flag does not follow the bus");

	a_idle_slave_only: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
		ce_i && (!slave_mode || sleep_i) |=> !flags[lin_status_pkg::IDLE_BIT])
		else $error("idle flag set outside awake slave mode");

	a_abort_on_break: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
		ce_i && slave_mode && (stop_cmd || (synch_break_i && in_tx))
		|=> flags[lin_status_pkg::ABORT_BIT])
		else $error("abort flag missed");

	a_abort_cleared: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
		ce_i && slave_mode && synch_break_i && !in_tx && !stop_cmd
		|=> !flags[lin_status_pkg::ABORT_BIT])
		else $error("abort flag not cleared by clean break");

	a_dreq_set: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
		ce_i && slave_mode && id_rx_i |=> flags[lin_status_pkg::DREQ_BIT])
		else $error("data request flag missed");

	a_int_held: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
		ce_i && flags[lin_status_pkg::INT_BIT] && !clr_int_cmd
		|=> flags[lin_status_pkg::INT_BIT])
		else $error("interrupt flag dropped without clear");

	a_err_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
		ce_i && clr_err_cmd && !err_i |=> !flags[lin_status_pkg::ERR_BIT])
		else $error("error flag not cleared");

	a_wake_tx: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
		ce_i && wake_tx_i |=> flags[lin_status_pkg::WAKE_BIT])
		else $error("wakeup flag low while sending");

	a_done_start: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
		ce_i && tx_start_i && !tx_end_i |=> !flags[lin_status_pkg::DONE_BIT])
		else $error("done flag not cleared at start");

	a_done_end: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
		ce_i && tx_end_i |=> flags[lin_status_pkg::DONE_BIT] && !in_tx)
		else $error("done flag not set at end");

	a_reset_zero: assert property (@(posedge clk_i) // RULE_11
		rst_i |=> status_o == 8'h00)
		else $error("status not zero after reset");

	a_status_ro: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_12
		ce_i && req && wb_we_i && (wb_adr_i[7:2] == lin_status_pkg::STATUS_IDX)
		&& hw_quiet |=> $stable(flags))
		else $error("status moved on a direct write");
endmodule
`default_nettype wire

// [verif/lin_node_model.sv]
// far-side lin node: turns bench requests into engine event pulses
// assumes requests are one-cycle patterns on clk_i
`timescale 1ns/10ps
`default_nettype none
module lin_node_model (
	// clock, reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bench side
	input wire logic [6:0] req_i,
	input wire logic slow_i,
	// engine side
	output logic [6:0] ev_o,
	output logic busy_o
);
	logic [6:0] pend; // events waiting to go out
	logic [3:0] wait_n; // slow answer delay
	// ==========================================
	// one-cycle pulses, prompt or after a delay
	always_ff @(posedge clk_i) begin
		ev_o <= 7'h00;
		if (rst_i) begin
			pend <= 7'h00;
			wait_n <= 4'h0;
		end else if (req_i != 7'h00) begin
			pend <= req_i;
			wait_n <= slow_i ? 4'h6 : 4'h0;
		end else if (wait_n != 4'h0) begin
			wait_n <= wait_n - 4'h1;
		end else if (pend != 7'h00) begin
			ev_o <= pend;
			pend <= 7'h00;
		end
	end
	assign busy_o = (pend != 7'h00);
endmodule
`default_nettype wire

// [verif/lin_status_flags_test.sv]
// bench for the lin status flags: table of events, then hand tests
// assumes the design with IDLE_CYCLES of 20 and a 5 ns clock
`timescale 1ns/10ps
`default_nettype none
module lin_status_flags_test;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0000_0000, wb_dat_o;
	logic wb_ack_o, act = 0, sleep = 0, wake_tx = 0, slow = 0, ce = 1;
	logic [23:0] hi; // upper read data lanes
	logic [6:0] req = 7'h00, ev;
	logic busy, stop_o, irq_o, seen_stop = 0;
	logic [7:0] status_o, q;
	int fail_count = 0, compares = 0;
	typedef struct packed {logic [6:0] ev; logic [7:0] exp;} row_s;
	// event pattern (brk,txs,txe,id,int,err,wkrx from bit 0) and status
	row_s rows [10] = '{'{7'h02, 8'h80}, '{7'h04, 8'h81}, '{7'h01, 8'h81},
		'{7'h08, 8'h91}, '{7'h02, 8'h90}, '{7'h01, 8'hA0}, '{7'h10, 8'hA8},
		'{7'h20, 8'hAC}, '{7'h40, 8'hAE}, '{7'h04, 8'hAF}};
	// ==========================================
	// clock, design, far side
	always #2.5 clk_i = ~clk_i;
	lin_status_flags #(.IDLE_CYCLES(20)) u_lin_status_flags (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.bus_active_i(act), .sleep_i(sleep), .synch_break_i(ev[0]), .tx_start_i(ev[1]),
		.tx_end_i(ev[2]), .id_rx_i(ev[3]), .int_req_i(ev[4]), .err_i(ev[5]),
		.wake_tx_i(wake_tx), .wake_rx_i(ev[6]), .status_o(status_o), .stop_o(stop_o),
		.irq_o(irq_o));
	lin_node_model u_lin_node_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
		.slow_i(slow), .ev_o(ev), .busy_o(busy));
	always @(posedge clk_i) if (stop_o === 1'b1) seen_stop <= 1'b1;
	// ==========================================
	// compare, bus cycle, event request
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// waits for ack as long as it takes; only the watchdog ends a hang
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= 4'h1; dat <= {24'h00_0000, d};
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o[7:0];
		hi = wb_dat_o[31:8];
		cyc <= 0; stb <= 0; we <= 0;
	endtask
	task fire(input logic [6:0] p);
		@(posedge clk_i) req <= p;
		@(posedge clk_i) req <= 7'h00;
		@(posedge clk_i);
		while (busy === 1'b1) begin
			@(posedge clk_i);
		end
		repeat (3) @(posedge clk_i);
	endtask
	task give_verdict;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ==========================================
	// watchdog
	initial begin
		repeat (5000) @(posedge clk_i);
		fail_count++;
		give_verdict;
	end
	// ==========================================
	// main sequence
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		wb(0, 8'h24, 8'h00);
		chk(q, 8'h00);
		chk(status_o, 8'h00);
		chk({7'h00, irq_o}, 8'h00);
		$display("test reset done");
		@(posedge clk_i) act <= 1;
		wb(1, 8'h2C, 8'h08);
		wb(1, 8'h20, 8'h01);
		foreach (rows[i]) begin
			slow <= i[0];
			fire(rows[i].ev);
			wb(0, 8'h24, 8'h00);
			chk(q, rows[i].exp);
		end
		$display("test table done");
		// interrupt flags, clear bits, sticky bits and mask
		wb(0, 8'h28, 8'h00);
		chk(q, 8'hBF);
		chk({7'h00, irq_o}, 8'h01);
		wb(1, 8'h20, 8'h0D);
		wb(0, 8'h24, 8'h00);
		chk(q, 8'hA3);
		wb(1, 8'h28, 8'hFF);
		wb(0, 8'h28, 8'h00);
		chk(q, 8'h00);
		chk({7'h00, irq_o}, 8'h00);
		fire(7'h30);
		chk(status_o, 8'hAF);
		chk({7'h00, irq_o}, 8'h01);
		wb(1, 8'h2C, 8'h00);
		@(posedge clk_i);
		chk({7'h00, irq_o}, 8'h00);
		$display("test interrupt done");
		// refused writes and unmapped place
		wb(1, 8'h24, 8'h00);
		wb(0, 8'h24, 8'h00);
		chk(q, 8'hAF);
		wb(1, 8'h3C, 8'hFF);
		wb(0, 8'h3C, 8'h00);
		chk(q, 8'h00);
		chk(hi[7:0] | hi[15:8] | hi[23:16], 8'h00);
		wb(0, 8'h20, 8'h00);
		chk(q, 8'h01);
		$display("test refused done");
		// clean break, then stop request
		fire(7'h01);
		chk(status_o, 8'h8F);
		wb(1, 8'h20, 8'h81);
		repeat (3) @(posedge clk_i);
		chk(status_o, 8'hAF);
		chk({7'h00, seen_stop}, 8'h01);
		$display("test stop done");
		// quiet bus in slave mode, then sleep
		@(posedge clk_i) act <= 0;
		repeat (30) @(posedge clk_i);
		chk(status_o, 8'h6F);
		@(posedge clk_i) sleep <= 1;
		repeat (3) @(posedge clk_i);
		chk(status_o, 8'h2F);
		$display("test idle done");
		// frozen clock enable: a start pulse is lost, flags hold
		@(posedge clk_i) ce <= 0;
		fire(7'h02);
		@(posedge clk_i) ce <= 1;
		@(posedge clk_i);
		chk(status_o, 8'h2F);
		$display("test freeze done");
		// reset again in mid-run, then a wakeup being sent
		@(posedge clk_i) rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		chk(status_o, 8'h00);
		chk({7'h00, irq_o}, 8'h00);
		@(posedge clk_i) wake_tx <= 1;
		repeat (2) @(posedge clk_i);
		chk(status_o, 8'h02);
		wake_tx <= 0;
		repeat (2) @(posedge clk_i);
		chk(status_o, 8'h00);
		$display("test reset again done");
		give_verdict;
	end
endmodule
`default_nettype wire
